// ### frtic_defines.vh
`ifndef FRTIC_DEFINES_VH
`define FRTIC_DEFINES_VH
// register byte offsets on the bus
`define FRTIC_OFF_COUNT 6'h00
`define FRTIC_OFF_CAP1 6'h04
`define FRTIC_OFF_CAP2 6'h08
`define FRTIC_OFF_CAP3 6'h0c
`define FRTIC_OFF_SHARED 6'h10
`define FRTIC_OFF_EDGE 6'h14
`define FRTIC_OFF_MASK1 6'h18
`define FRTIC_OFF_FLAGS1 6'h1c
`define FRTIC_OFF_MASK2 6'h20
`define FRTIC_OFF_FLAGS2 6'h24
`define FRTIC_OFF_ACCCTL 6'h28
`define FRTIC_OFF_DIR 6'h2c
`define FRTIC_OFF_PINOUT 6'h30
`define FRTIC_OFF_NONE 6'h3f
// field positions
`define FRTIC_BIT_OVF 7
`define FRTIC_BIT_OVIE 7
`define FRTIC_BIT_SHSEL 2
`define FRTIC_BIT_PIN3 3
`define FRTIC_BIT_IC4 3
`define FRTIC_BIT_IC1 2
`define FRTIC_BIT_IC2 1
`define FRTIC_BIT_IC3 0
// timing and response codes
`define FRTIC_PRESCALE_WINDOW 8'd64
`define FRTIC_RESP_OKAY 2'b00
`define FRTIC_RESP_SLVERR 2'b10
`endif

// ### frtic_pin_source.sv
`default_nettype none
module frtic_pin_source (
    input wire logic [3:0] level, // wanted pin levels
    input wire logic slow, // late settling
    output var logic [3:0] capture_pin // port a pins 3..0
);
    timeunit 1ns;
    timeprecision 1ps;
    initial capture_pin = 4'h0;
    // sources are unclocked: edges land 3 ns or 13 ns after each level change
    always @(level) capture_pin <= #(slow ? 13 : 3) level;
endmodule // frtic_pin_source
`default_nettype wire

// ### frtic_timer.v
// Notes on behaviour
// - prescaled bus clock advances free-running counter
// - prescale select written once, first 64 cycles
// - counter reads never disturb its value
// - counter clears on reset, read-only, wraps
// - rollover to zero sets overflow flag
// - overflow flag with enable raises interrupt
// - three capture registers plus shared register
// - capture registers not reset
// - selected pin edge latches counter value
// - capture edge can request an interrupt
// - direction bits reset zero; clear for capture
// - shared channel captures only when selected
// - pin three output writes also capture
// - writes ignored while shared register captures
// - edge field: off, rise, fall, both
// - four edge pairs, cleared on reset
// - wait with mask, no watchdog stops timer
// - flag set per edge, write-one clears
// - flag and enable raise capture interrupt
// - prescale codes divide 1, 4, 8, 16
// - special mode permits prescale writes anytime
//
// Register access over AXI4-Lite and the address map were decided locally.
`include "frtic_defines.vh"
`default_nettype none
module frtic_timer #(
    parameter CHANNELS = 4
) (
    input wire aclk, // bus clock
    input wire aresetn, // synchronous reset, active low
    input wire [3:0] capture_pin, // port a pins three..zero
    input wire special_mode, // special operating mode strap
    input wire wait_instruction, // cpu is in wait mode
    input wire cpu_irq_masked, // cpu interrupt mask bit set
    input wire watchdog_enabled, // watchdog monitor running
    input wire [31:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [31:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    output reg [3:0] port_a_direction, // direction bits, pins 3..0
    output reg pin_three_drive, // level software drives on pin three
    output reg overflow_irq, // overflow interrupt request
    output reg capture_irq // capture interrupt request
);
    reg [15:0] free_running_count;
    reg [15:0] capture_one;
    reg [15:0] capture_two;
    reg [15:0] capture_three;
    reg [15:0] shared_capture_compare;
    reg [7:0] capture_edge_control;
    reg [7:0] first_timer_mask;
    reg [7:0] first_timer_flags;
    reg [7:0] second_timer_mask;
    reg [7:0] second_timer_flags;
    reg [7:0] accumulator_control;
    reg prescale_select_high;
    reg prescale_select_low;
    reg prescale_written;
    reg [7:0] init_cycles;
    reg [3:0] prescaler;
    reg [3:0] sync_a;
    reg [3:0] sync_b;
    reg [3:0] sync_prev;
    reg pin3_prev;
    reg [5:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    wire [3:0] pin_level;
    wire timer_stopped;
    wire tick;
    wire wr_go;
    wire [3:0] cap_event;
    wire shared_is_capture;
    reg [3:0] prescale_limit;
    reg [31:0] next_rdata;
    reg next_rresp_err;
    reg wr_err;
    integer i;

    function edge_hit;
        input [1:0] sel;
        input prev;
        input now;
        begin
            edge_hit = (sel[0] & ~prev & now) | (sel[1] & prev & ~now);
        end
    endfunction

    assign shared_is_capture = accumulator_control[`FRTIC_BIT_SHSEL];
    assign timer_stopped = wait_instruction & cpu_irq_masked &
                           ~watchdog_enabled;
    always @* begin
        case ({prescale_select_high, prescale_select_low})
            2'b00: prescale_limit = 4'h0;
            2'b01: prescale_limit = 4'h3;
            2'b10: prescale_limit = 4'h7;
            default: prescale_limit = 4'hf;
        endcase
    end
    // compare with >= so a smaller divide chosen mid-period ticks at once
    // instead of wrapping the prescaler through all sixteen states
    assign tick = ~timer_stopped && (prescaler >= prescale_limit);

    // pin three as output: the driven level feeds the detector directly
    assign pin_level = {port_a_direction[`FRTIC_BIT_PIN3] ? pin_three_drive :
                        sync_b[3], sync_b[2:0]};

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : gen_edge
            if (g == 3) begin : gen_shared
                assign cap_event[g] = shared_is_capture & ~timer_stopped &
                    edge_hit(capture_edge_control[1:0], pin3_prev,
                             pin_level[3]);
            end else begin : gen_plain
                assign cap_event[g] = ~timer_stopped &
                    edge_hit(capture_edge_control[2*(3-g)+1 -: 2],
                             sync_prev[g], pin_level[g]);
            end
        end
    endgenerate

    always @(posedge aclk) begin
        sync_a <= capture_pin;
        sync_b <= sync_a;
        sync_prev <= sync_b;
        pin3_prev <= pin_level[3];
    end

    // capture registers have no reset branch
    always @(posedge aclk) begin
        if (cap_event[0])
            capture_one <= free_running_count;
        if (cap_event[1])
            capture_two <= free_running_count;
        if (cap_event[2])
            capture_three <= free_running_count;
        if (cap_event[3])
            shared_capture_compare <= free_running_count;
        else if (wr_go && w_strb[0] && aw_addr == `FRTIC_OFF_SHARED &&
                 !shared_is_capture)
            shared_capture_compare <= w_data[15:0];
    end

    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    // one decoder serves both channels, so reads and writes share the map
    function reg_known;
        input [31:0] addr;
        begin
            case (addr)
                {26'h0, `FRTIC_OFF_COUNT},
                {26'h0, `FRTIC_OFF_CAP1},
                {26'h0, `FRTIC_OFF_CAP2},
                {26'h0, `FRTIC_OFF_CAP3},
                {26'h0, `FRTIC_OFF_SHARED},
                {26'h0, `FRTIC_OFF_EDGE},
                {26'h0, `FRTIC_OFF_MASK1},
                {26'h0, `FRTIC_OFF_FLAGS1},
                {26'h0, `FRTIC_OFF_MASK2},
                {26'h0, `FRTIC_OFF_FLAGS2},
                {26'h0, `FRTIC_OFF_ACCCTL},
                {26'h0, `FRTIC_OFF_DIR},
                {26'h0, `FRTIC_OFF_PINOUT}: reg_known = 1'b1;
                default: reg_known = 1'b0;
            endcase
        end
    endfunction

    // unmapped reads answer zero with an error
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp_err = ~reg_known(s_axi_araddr);
        case (s_axi_araddr[5:0])
            `FRTIC_OFF_COUNT: next_rdata[15:0] = free_running_count;
            `FRTIC_OFF_CAP1: next_rdata[15:0] = capture_one;
            `FRTIC_OFF_CAP2: next_rdata[15:0] = capture_two;
            `FRTIC_OFF_CAP3: next_rdata[15:0] = capture_three;
            `FRTIC_OFF_SHARED: next_rdata[15:0] = shared_capture_compare;
            `FRTIC_OFF_EDGE: next_rdata[7:0] = capture_edge_control;
            `FRTIC_OFF_MASK1: next_rdata[7:0] = first_timer_mask;
            `FRTIC_OFF_FLAGS1: next_rdata[7:0] = first_timer_flags;
            `FRTIC_OFF_MASK2: next_rdata[7:0] = second_timer_mask |
                {6'h00, prescale_select_high, prescale_select_low};
            `FRTIC_OFF_FLAGS2: next_rdata[7:0] = second_timer_flags;
            `FRTIC_OFF_ACCCTL: next_rdata[7:0] = accumulator_control;
            `FRTIC_OFF_DIR: next_rdata[3:0] = port_a_direction;
            `FRTIC_OFF_PINOUT: next_rdata[`FRTIC_BIT_PIN3] = pin_three_drive;
            default: next_rdata = 32'h0000_0000;
        endcase
        if (next_rresp_err)
            next_rdata = 32'h0000_0000;
    end

    always @* begin
        wr_err = ~reg_known({26'h0, aw_addr});
    end

    // the counter has no write path, so no read or write can disturb it
    always @(posedge aclk) begin
        if (!aresetn) begin
            free_running_count <= 16'h0000;
            prescaler <= 4'h0;
            init_cycles <= 8'h00;
        end else begin
            if (init_cycles != `FRTIC_PRESCALE_WINDOW)
                init_cycles <= init_cycles + 8'd1;
            // wait mode with the mask set and no watchdog freezes the prescaler phase as well as the count
            if (!timer_stopped)
                prescaler <= tick ? 4'h0 : prescaler + 4'h1;
            if (tick)
                free_running_count <= free_running_count + 16'h0001;
        end
    end

    // address and data are latched in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FRTIC_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                // out-of-range addresses park on an unmapped offset
                if (s_axi_awaddr[31:6] != 26'h0)
                    aw_addr <= `FRTIC_OFF_NONE;
                else
                    aw_addr <= s_axi_awaddr[5:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? `FRTIC_RESP_SLVERR : `FRTIC_RESP_OKAY;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            capture_edge_control <= 8'h00;
            first_timer_mask <= 8'h00;
            second_timer_mask <= 8'h00;
            accumulator_control <= 8'h00;
            port_a_direction <= 4'h0;
            pin_three_drive <= 1'b0;
            prescale_select_high <= 1'b0;
            prescale_select_low <= 1'b0;
            prescale_written <= 1'b0;
        end else if (wr_go && w_strb[0]) begin
            case (aw_addr)
                `FRTIC_OFF_EDGE: capture_edge_control <= w_data[7:0];
                `FRTIC_OFF_MASK1: first_timer_mask <= w_data[7:0];
                `FRTIC_OFF_MASK2: begin
                    second_timer_mask <= {w_data[7:4], 4'h0};
                    // late writes still answer okay; only the divide holds
                    if (special_mode || (!prescale_written &&
                        init_cycles != `FRTIC_PRESCALE_WINDOW)) begin
                        prescale_select_high <= w_data[1];
                        prescale_select_low <= w_data[0];
                        prescale_written <= 1'b1;
                    end
                end
                `FRTIC_OFF_ACCCTL: accumulator_control <= w_data[7:0];
                `FRTIC_OFF_DIR: port_a_direction <= w_data[3:0];
                `FRTIC_OFF_PINOUT: pin_three_drive <= w_data[3];
                default: ;
            endcase
        end
    end

    // set wins over a simultaneous write-one clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            first_timer_flags <= 8'h00;
            second_timer_flags <= 8'h00;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (wr_go && w_strb[0] && aw_addr == `FRTIC_OFF_FLAGS1 &&
                    w_data[i])
                    first_timer_flags[i] <= 1'b0;
                if (wr_go && w_strb[0] && aw_addr == `FRTIC_OFF_FLAGS2 &&
                    w_data[i])
                    second_timer_flags[i] <= 1'b0;
            end
            if (cap_event[0])
                first_timer_flags[`FRTIC_BIT_IC1] <= 1'b1;
            if (cap_event[1])
                first_timer_flags[`FRTIC_BIT_IC2] <= 1'b1;
            if (cap_event[2])
                first_timer_flags[`FRTIC_BIT_IC3] <= 1'b1;
            if (cap_event[3])
                first_timer_flags[`FRTIC_BIT_IC4] <= 1'b1;
            if (tick && free_running_count == 16'hffff)
                second_timer_flags[`FRTIC_BIT_OVF] <= 1'b1;
        end
    end

    // requests trail their flags by one cycle so they leave from a flop
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_irq <= 1'b0;
            capture_irq <= 1'b0;
        end else begin
            overflow_irq <= second_timer_flags[`FRTIC_BIT_OVF] &
                            second_timer_mask[`FRTIC_BIT_OVIE];
            capture_irq <= |(first_timer_flags[3:0] &
                             first_timer_mask[3:0]);
        end
    end

    // the master holds araddr until arready, so it is decoded at that edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `FRTIC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp_err ? `FRTIC_RESP_SLVERR :
                               `FRTIC_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // frtic_timer
`default_nettype wire

// ### frtic_timer_assertions.sv
`default_nettype none
module frtic_timer_assertions (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset, low
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [3:0] port_a_direction, // direction bits
    input wire logic pin_three_drive, // pin three level
    input wire logic overflow_irq, // overflow request
    input wire logic capture_irq // capture request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_quiet: assert property ($rose(aresetn) |->
        port_a_direction == 4'h0 && !overflow_irq && !capture_irq)
        else $error("outputs not cleared by reset");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_single: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    chk_write_answer: assert property (
        s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    // register outputs may only move as the tail of a bus write
    chk_dir_cause: assert property (!$stable(port_a_direction) |->
        $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) ||
        $past(s_axi_wvalid, 3)) else $error("direction moved alone");
    chk_pin3_cause: assert property (!$stable(pin_three_drive) |->
        $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) ||
        $past(s_axi_wvalid, 3)) else $error("pin three moved alone");
    chk_ovf_clear: assert property ($fell(overflow_irq) |->
        $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3) ||
        $past(s_axi_wvalid, 4)) else $error("overflow request dropped");
    chk_cap_clear: assert property ($fell(capture_irq) |->
        $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3) ||
        $past(s_axi_wvalid, 4)) else $error("capture request dropped");
    cov_cap: cover property ($rose(capture_irq));
    cov_ovf: cover property ($rose(overflow_irq));
    cov_wr: cover property (s_axi_bvalid);
endmodule // frtic_timer_assertions
`default_nettype wire

// ### tb_free_running_timer_input_capture.sv
`include "frtic_defines.vh"
`default_nettype none
module tb_free_running_timer_input_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, smode = 0, wt = 0, msk = 0, wd = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d, a, b, c;
    logic awready, wready, bvalid, arready, rvalid, pin3, oirq, cirq;
    logic [1:0] bresp, rresp, rr, wb;
    logic [3:0] pins, dir, lvl = 0;
    logic slow = 0;
    int n_fail = 0, n_checks = 0, cyc = 0, rcyc, code[4], ec, i, e, n;
    frtic_timer uut (.aclk, .aresetn, .capture_pin(pins),
        .special_mode(smode), .wait_instruction(wt), .cpu_irq_masked(msk),
        .watchdog_enabled(wd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_a_direction(dir), .pin_three_drive(pin3), .overflow_irq(oirq),
        .capture_irq(cirq));
    frtic_pin_source src (.level(lvl), .slow(slow), .capture_pin(pins));
    initial begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    task finish_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk_data(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR %0t data %h expected %h", $time, g, x);
        end
    endtask
    task chk_resp(input logic [1:0] g, input logic [1:0] x);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR %0t response %b expected %b", $time, g, x);
        end
    endtask
    task wr(input logic [31:0] ad, input logic [31:0] dt);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && k < 40);
        wb = bresp;
        bready <= 1'b0;
        if (!bvalid) begin
            n_fail++;
            finish_test();
        end
    endtask
    task rd(input logic [31:0] ad, output logic [31:0] dt);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && k < 40);
        dt = rdata;
        rr = rresp;
        rcyc = cyc;
        rready <= 1'b0;
        if (!rvalid) begin
            n_fail++;
            finish_test();
        end
    endtask
    // prescaler phase is unknown, so one extra count is legal when the span is not a whole number of periods
    task rate(input int dv);
        int t, x;
        rd(`FRTIC_OFF_COUNT, a);
        t = rcyc;
        repeat (40) @(posedge aclk);
        rd(`FRTIC_OFF_COUNT, b);
        t = rcyc - t;
        x = t / dv;
        if (b - a == x + 1 && t % dv != 0) x++;
        chk_data(b - a, x);
    endtask
    initial begin
        void'($urandom(32'hf799c3aa));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`FRTIC_OFF_DIR, d);
        chk_data(d, 0);
        rd(`FRTIC_OFF_EDGE, d);
        chk_data(d, 0);
        wr(`FRTIC_OFF_MASK2, 1);
        rate(4);
        wr(`FRTIC_OFF_MASK2, 3);
        rate(4);
        smode <= 1'b1;
        for (i = 3; i >= 0; i--) begin
            wr(`FRTIC_OFF_MASK2, i);
            rate(i ? 2 << i : 1);
        end
        rd(32'h40, d);
        chk_resp(rr, `FRTIC_RESP_SLVERR);
        wr(32'h40, 1);
        chk_resp(wb, `FRTIC_RESP_SLVERR);
        $display("prescale test done");
        wr(`FRTIC_OFF_SHARED, 32'h1234);
        chk_resp(wb, `FRTIC_RESP_OKAY);
        rd(`FRTIC_OFF_SHARED, d);
        chk_data(d, 32'h1234);
        wr(`FRTIC_OFF_ACCCTL, 4);
        wr(`FRTIC_OFF_SHARED, 32'h5678);
        rd(`FRTIC_OFF_SHARED, d);
        chk_data(d, 32'h1234);
        e = $urandom;
        ec = 0;
        for (i = 0; i < 4; i++) begin
            code[i] = (i + e) & 3;
            ec = ec | code[i] << (6 - 2 * i);
        end
        wr(`FRTIC_OFF_EDGE, ec);
        wr(`FRTIC_OFF_MASK1, 15);
        for (i = 0; i < 8; i++) begin
            slow <= i[0];
            rd(`FRTIC_OFF_COUNT, a);
            lvl[i / 2] <= !i[0];
            repeat (8) @(posedge aclk);
            rd(`FRTIC_OFF_COUNT, b);
            rd(`FRTIC_OFF_FLAGS1, d);
            n = (code[i / 2] >> i[0]) & 1;
            chk_data(d[i / 2 == 3 ? 3 : 2 - i / 2], n);
            chk_data(cirq, n);
            if (n) begin
                rd(4 + 4 * (i / 2), c);
                chk_data(c >= a && c <= b, 1);
            end
            wr(`FRTIC_OFF_FLAGS1, 15);
            rd(`FRTIC_OFF_FLAGS1, d);
            chk_data(d, 0);
        end
        wr(`FRTIC_OFF_DIR, 8);
        wr(`FRTIC_OFF_PINOUT, 8);
        repeat (8) @(posedge aclk);
        rd(`FRTIC_OFF_FLAGS1, d);
        chk_data(d[3], code[3] & 1);
        $display("capture test done");
        wt <= 1'b1;
        msk <= 1'b1;
        rd(`FRTIC_OFF_COUNT, a);
        repeat (20) @(posedge aclk);
        rd(`FRTIC_OFF_COUNT, b);
        chk_data(b, a);
        wd <= 1'b1;
        rd(`FRTIC_OFF_COUNT, c);
        chk_data(c > b, 1);
        wt <= 1'b0;
        wr(`FRTIC_OFF_MASK2, 32'h80);
        n = 0;
        while (!oirq && n < 70000) begin
            @(posedge aclk);
            n++;
        end
        chk_data(oirq, 1);
        rd(`FRTIC_OFF_FLAGS2, d);
        chk_data(d[7], 1);
        wr(`FRTIC_OFF_FLAGS2, 32'h80);
        rd(`FRTIC_OFF_FLAGS2, d);
        chk_data(d[7], 0);
        $display("overflow test done");
        finish_test();
    end
endmodule // tb_free_running_timer_input_capture
bind frtic_timer frtic_timer_assertions chk (.aclk, .aresetn,
    .s_axi_awready, .s_axi_wready, .s_axi_wvalid, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .port_a_direction, .pin_three_drive, .overflow_irq, .capture_irq);
`default_nettype wire
